// file: hw/wdt_counter.sv
`timescale 1ns/10ps
module wdt_counter (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Control
  input  wire logic         run,
  input  wire logic         fil_tick,
  input  wire logic         standby,
  input  wire wdt_pkg::opt_s opt,
  input  wire logic         clear_req,
  input  wire logic         restart,
  // Status
  output logic [16:0]       count,
  output logic              closed,
  output logic              ovf,
  output logic              irq
);
  import wdt_pkg::*;

  typedef struct packed {
    logic [16:0] count;
    logic        clr_pend;
    logic        ovf;
    logic        irq;
  } cnt_state_s;

  cnt_state_s st_r;
  cnt_state_s st_nxt;
  logic       halted;
  logic [16:0] inc;

  always_comb
  begin
    halted     = !opt.run_in_standby_opt && standby;
    inc        = st_r.count + 17'h00001;
    st_nxt     = st_r;
    st_nxt.ovf = 1'b0;
    st_nxt.irq = 1'b0;
    // A key write is held until the next oscillator tick takes it.
    if (clear_req)
      st_nxt.clr_pend = 1'b1;
    if (restart || !run)
    begin
      st_nxt.count    = '0;
      st_nxt.clr_pend = 1'b0;
    end
    else if (halted)
    begin
      // Holding zero while halted makes the exit restart from zero.
      st_nxt.count    = '0;
      st_nxt.clr_pend = 1'b0;
    end
    else if (fil_tick)
    begin
      if (st_nxt.clr_pend)
      begin
        st_nxt.count    = '0;
        st_nxt.clr_pend = 1'b0;
      end
      else if (st_r.count == ovf_len(opt) - 17'h00001)
      begin
        st_nxt.ovf   = 1'b1;
        st_nxt.count = '0;
      end
      else
      begin
        st_nxt.count = inc;
        if (opt.interval_irq_opt && inc == irq_point(opt))
          st_nxt.irq = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign count  = st_r.count;
  assign closed = window_closed(opt, st_r.count);
  assign ovf    = st_r.ovf;
  assign irq    = st_r.irq;

endmodule

// file: hw/wdt_pkg.sv
package wdt_pkg;

  localparam int          ADDR_W        = 22;
  localparam int          CNT_W         = 17;
  localparam logic [19:0] IDX_CLEAR     = 20'hFFFAB;
  localparam logic [19:0] IDX_BITOP     = 20'hFFFAC;
  localparam logic [19:0] IDX_CAUSE     = 20'hFFFAD;
  localparam logic [19:0] IDX_STATUS    = 20'hFFFAE;
  localparam logic [7:0]  CLEAR_KEY     = 8'hAC;
  localparam logic [7:0]  RD_ENABLED    = 8'h9A;
  localparam logic [7:0]  RD_DISABLED   = 8'h1A;
  localparam int          CAUSE_WD_BIT  = 4;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  localparam logic [7:0]  OPT_RESET     = 8'h00;
  localparam logic [16:0] LEN_2E6       = 17'h00040;
  localparam logic [16:0] LEN_2E7       = 17'h00080;
  localparam logic [16:0] LEN_2E8       = 17'h00100;
  localparam logic [16:0] LEN_2E9       = 17'h00200;
  localparam logic [16:0] LEN_2E11      = 17'h00800;
  localparam logic [1:0]  WIN_OPEN_50   = 2'h1;
  localparam logic [1:0]  WIN_OPEN_75   = 2'h2;

  // Option byte, bit 7 down to bit 0.
  typedef struct packed {
    logic interval_irq_opt;
    logic open_period_sel_b1;
    logic open_period_sel_b0;
    logic count_enable_opt;
    logic overflow_sel_b2;
    logic overflow_sel_b1;
    logic overflow_sel_b0;
    logic run_in_standby_opt;
  } opt_s;

  // Prohibited codes fall back to the longest period so a bad option cannot shorten it.
  function automatic logic [16:0] ovf_len(input opt_s o);
    case ({o.overflow_sel_b2, o.overflow_sel_b1, o.overflow_sel_b0})
      3'h0:    ovf_len = LEN_2E6;
      3'h1:    ovf_len = LEN_2E7;
      3'h2:    ovf_len = LEN_2E8;
      3'h3:    ovf_len = LEN_2E9;
      default: ovf_len = LEN_2E11;
    endcase
  endfunction

  function automatic logic [16:0] irq_point(input opt_s o);
    irq_point = ovf_len(o) - (ovf_len(o) >> 2);
  endfunction

  function automatic logic window_closed(input opt_s o, input logic [16:0] c);
    window_closed = 1'b0;
    if (o.run_in_standby_opt)
    begin
      case ({o.open_period_sel_b1, o.open_period_sel_b0})
        WIN_OPEN_50: window_closed = c < (ovf_len(o) >> 1);
        WIN_OPEN_75: window_closed = c < (ovf_len(o) >> 2);
        default:     window_closed = 1'b0;
      endcase
    end
  endfunction

endpackage

// file: hw/windowed_watchdog_timer.sv
`timescale 1ns/10ps
module windowed_watchdog_timer (
  // Clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // Option byte, oscillator tick and power modes
  input  wire logic [7:0]                opt_byte,
  input  wire logic                      fil_tick,
  input  wire logic                      halt_mode,
  input  wire logic                      stop_mode,
  // AXI4-Lite write address and data
  input  wire logic [wdt_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  // AXI4-Lite read
  input  wire logic [wdt_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // Watchdog outputs
  output logic                           wd_reset_req,
  output logic                           wd_reset_cause_flag,
  output logic                           interval_irq
);
  import wdt_pkg::*;

  typedef enum logic [1:0] {
    WS_COLLECT = 2'h1,
    WS_RESP    = 2'h2
  } wr_state_e;

  typedef enum logic [1:0] {
    RS_IDLE = 2'h1,
    RS_DATA = 2'h2
  } rd_state_e;

  // Outcome of a committed write to the clear register.
  typedef enum logic [2:0] {
    KV_IGNORE = 3'h1,
    KV_CLEAR  = 3'h2,
    KV_FAULT  = 3'h4
  } key_verdict_e;

  typedef struct packed {
    wr_state_e   ws;
    rd_state_e   rs;
    logic        awready;
    logic        wready;
    logic        aw_got;
    logic        w_got;
    logic [19:0] waddr;
    logic [7:0]  wbyte;
    logic        wlane0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    opt_s        opt;
    logic        opt_loaded;
    logic        first_done;
    logic        cause_flag;
    logic        reset_req;
    logic        clear_req;
    logic        restart;
  } wd_state_s;

  wd_state_s   st_r;
  wd_state_s   st_nxt;
  logic        run;
  logic [16:0] count;
  logic        closed;
  logic        ovf;
  logic        irq;

  assign run = st_r.opt_loaded && st_r.opt.count_enable_opt;

  // The counter sees only the captured options, never the live strap pins.
  wdt_counter i_wdt_counter (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .run       (run),
    .fil_tick  (fil_tick),
    .standby   (halt_mode || stop_mode),
    .opt       (st_r.opt),
    .clear_req (st_r.clear_req),
    .restart   (st_r.restart),
    .count     (count),
    .closed    (closed),
    .ovf       (ovf),
    .irq       (irq)
  );

  // Debug view of the counter; bits 23 to 19 read as zero.
  function automatic logic [31:0] status_word(input wd_state_s s, input logic [16:0] c,
                                              input logic cl);
    status_word = {s.opt, 5'h00, s.first_done, cl, c};
  endfunction

  // A store with byte lane 0 off, or one made while counting is off, changes nothing.
  function automatic key_verdict_e key_verdict(input wd_state_s s, input logic running,
                                               input logic in_closed);
    key_verdict = KV_IGNORE;
    if (s.wlane0 && running)
    begin
      if (s.wbyte != CLEAR_KEY)
        key_verdict = KV_FAULT;
      else if (s.first_done && in_closed)
        key_verdict = KV_FAULT;
      else
        key_verdict = KV_CLEAR;
    end
  endfunction

  // Only a store with byte lane 0 on and bit 4 set clears the flag; the other bits are ignored.
  function automatic logic cause_write_clears(input wd_state_s s);
    cause_write_clears = s.wlane0 && s.wbyte[CAUSE_WD_BIT];
  endfunction

  function automatic logic [31:0] read_word(input logic [19:0] idx, input wd_state_s s,
                                            input logic [16:0] c, input logic cl);
    case (idx)
      IDX_CLEAR:  read_word = {24'h000000, s.opt.count_enable_opt ? RD_ENABLED : RD_DISABLED};
      IDX_BITOP:  read_word = 32'h00000000;
      IDX_CAUSE:  read_word = {27'h0000000, s.cause_flag, 4'h0};
      IDX_STATUS: read_word = status_word(s, c, cl);
      default:    read_word = 32'h00000000;
    endcase
  endfunction

  function automatic logic is_mapped(input logic [19:0] idx);
    is_mapped = (idx == IDX_CLEAR) || (idx == IDX_BITOP) ||
                (idx == IDX_CAUSE) || (idx == IDX_STATUS);
  endfunction

  always_comb
  begin
    logic fault;
    fault            = 1'b0;
    st_nxt           = st_r;
    st_nxt.clear_req = 1'b0;
    st_nxt.restart   = 1'b0;
    st_nxt.reset_req = 1'b0;

    // Options are taken one cycle after release, so reset itself only loads constants.
    if (!st_r.opt_loaded)
    begin
      st_nxt.opt        = opt_s'(opt_byte);
      st_nxt.opt_loaded = 1'b1;
    end

    case (st_r.ws)
      WS_COLLECT:
      begin
        if (s_axi_awvalid && st_r.awready)
        begin
          st_nxt.waddr  = s_axi_awaddr[ADDR_W-1:2];
          st_nxt.aw_got = 1'b1;
        end
        if (s_axi_wvalid && st_r.wready)
        begin
          st_nxt.wbyte  = s_axi_wdata[7:0];
          st_nxt.wlane0 = s_axi_wstrb[0];
          st_nxt.w_got  = 1'b1;
        end
        if (st_r.aw_got && st_r.w_got)
        begin
          st_nxt.bvalid = 1'b1;
          st_nxt.bresp  = is_mapped(st_r.waddr) ? RESP_OKAY : RESP_SLVERR;
          st_nxt.ws     = WS_RESP;
          case (st_r.waddr)
            IDX_CLEAR:
            begin
              case (key_verdict(st_r, run, closed))
                KV_FAULT:
                begin
                  fault = 1'b1;
                end
                KV_CLEAR:
                begin
                  st_nxt.clear_req  = 1'b1;
                  st_nxt.first_done = 1'b1;
                end
                default:
                begin
                  st_nxt.clear_req = 1'b0;
                end
              endcase
            end
            IDX_BITOP:
            begin
              if (run)
                fault = 1'b1;
            end
            IDX_CAUSE:
            begin
              if (cause_write_clears(st_r))
                st_nxt.cause_flag = 1'b0;
            end
            default:
            begin
              st_nxt.bresp = st_nxt.bresp;
            end
          endcase
        end
      end
      WS_RESP:
      begin
        // Both channels reopen together in the cycle after the response is accepted.
        if (s_axi_bready)
        begin
          st_nxt.bvalid = 1'b0;
          st_nxt.aw_got = 1'b0;
          st_nxt.w_got  = 1'b0;
          st_nxt.ws     = WS_COLLECT;
        end
      end
      default:
      begin
        st_nxt.ws = WS_COLLECT;
      end
    endcase
    // Each channel is taken once per write and stays blocked until the response is accepted.
    st_nxt.awready = (st_nxt.ws == WS_COLLECT) && !st_nxt.aw_got;
    st_nxt.wready  = (st_nxt.ws == WS_COLLECT) && !st_nxt.w_got;

    case (st_r.rs)
      RS_IDLE:
      begin
        if (s_axi_arvalid && st_r.arready)
        begin
          st_nxt.rvalid = 1'b1;
          // Read data is captured at acceptance, so it holds still while rvalid stands.
          st_nxt.rdata  = read_word(s_axi_araddr[ADDR_W-1:2], st_r, count, closed);
          st_nxt.rresp  = is_mapped(s_axi_araddr[ADDR_W-1:2]) ? RESP_OKAY : RESP_SLVERR;
          st_nxt.rs     = RS_DATA;
        end
      end
      RS_DATA:
      begin
        if (s_axi_rready)
        begin
          st_nxt.rvalid = 1'b0;
          st_nxt.rs     = RS_IDLE;
        end
      end
      default:
      begin
        st_nxt.rs = RS_IDLE;
      end
    endcase
    st_nxt.arready = (st_nxt.rs == RS_IDLE);

    // An overflow needs no bus activity; it faults through the same path as a bad write.
    if (ovf)
      fault = 1'b1;
    // Placed after the software clear so a fresh fault always leaves the cause flag set.
    if (fault)
    begin
      st_nxt.reset_req  = 1'b1;
      // The restart also drops the first-key state, so the next key ignores the window.
      st_nxt.restart    = 1'b1;
      st_nxt.cause_flag = 1'b1;
      st_nxt.first_done = 1'b0;
      st_nxt.clear_req  = 1'b0;
    end
  end

  // The bus state codes are one-hot, so an all-zero reset would be illegal for them.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r     <= '0;
      st_r.ws  <= WS_COLLECT;
      st_r.rs  <= RS_IDLE;
      st_r.opt <= opt_s'(OPT_RESET);
    end
    else
      st_r <= st_nxt;
  end

  assign s_axi_awready       = st_r.awready;
  assign s_axi_wready        = st_r.wready;
  assign s_axi_bresp         = st_r.bresp;
  assign s_axi_bvalid        = st_r.bvalid;
  assign s_axi_arready       = st_r.arready;
  assign s_axi_rdata         = st_r.rdata;
  assign s_axi_rresp         = st_r.rresp;
  assign s_axi_rvalid        = st_r.rvalid;
  assign wd_reset_req        = st_r.reset_req;
  assign wd_reset_cause_flag = st_r.cause_flag;
  assign interval_irq        = irq;

endmodule

// file: test/cpu_master.sv
`timescale 1ns/10ps
module cpu_master (
  // Clock
  input  wire logic                       aclk,
  // Write channels
  output logic [wdt_pkg::ADDR_W-1:0]      s_axi_awaddr,
  output logic                            s_axi_awvalid,
  input  wire logic                       s_axi_awready,
  output logic [31:0]                     s_axi_wdata,
  output logic [3:0]                      s_axi_wstrb,
  output logic                            s_axi_wvalid,
  input  wire logic                       s_axi_wready,
  input  wire logic [1:0]                 s_axi_bresp,
  input  wire logic                       s_axi_bvalid,
  output logic                            s_axi_bready,
  // Read channels
  output logic [wdt_pkg::ADDR_W-1:0]      s_axi_araddr,
  output logic                            s_axi_arvalid,
  input  wire logic                       s_axi_arready,
  input  wire logic [31:0]                s_axi_rdata,
  input  wire logic [1:0]                 s_axi_rresp,
  input  wire logic                       s_axi_rvalid,
  output logic                            s_axi_rready
);
  initial
  begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
  end

  // Byte lane 0 carries the whole register, with all four strobes set as a 32-bit store would.
  task automatic wr(input logic [19:0] idx, input logic [7:0] d, output logic [1:0] r);
    logic aw_done;
    logic w_done;
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw_done = 1'b0;
    w_done = 1'b0;
    while (!(aw_done && w_done))
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [19:0] idx, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    while (!s_axi_arready) @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

// file: test/wdt_checker.sv
`timescale 1ns/10ps
module wdt_checker (
  // Clock and reset
  input wire logic                       aclk,
  input wire logic                       aresetn,
  // Watched ports
  input wire logic [7:0]                 opt_byte,
  input wire logic [wdt_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic                       s_axi_awvalid,
  input wire logic                       s_axi_awready,
  input wire logic                       s_axi_bvalid,
  input wire logic [wdt_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic                       s_axi_arvalid,
  input wire logic                       s_axi_arready,
  input wire logic [31:0]                s_axi_rdata,
  input wire logic                       s_axi_rvalid,
  input wire logic                       wd_reset_req,
  input wire logic                       wd_reset_cause_flag,
  input wire logic                       interval_irq
);
  import wdt_pkg::*;
  logic aw_take;
  logic ar_take;
  logic bitop_wr;
  logic clr_rd;
  assign aw_take  = s_axi_awvalid && s_axi_awready;
  assign ar_take  = s_axi_arvalid && s_axi_arready;
  assign bitop_wr = aw_take && s_axi_awaddr == {IDX_BITOP, 2'b00} && opt_byte[4];
  assign clr_rd   = ar_take && s_axi_araddr == {IDX_CLEAR, 2'b00};
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  AST_RST_PULSE: assert property (wd_reset_req |=> !wd_reset_req)
    else $error("reset request longer than one cycle");
  AST_IRQ_PULSE: assert property (interval_irq |=> !interval_irq [*8])
    else $error("interval interrupt repeated too soon");
  AST_IRQ_OPT: assert property (interval_irq |-> opt_byte[7])
    else $error("interval interrupt while disabled");
  AST_CAUSE_SET: assert property (wd_reset_req |-> ##[0:1] wd_reset_cause_flag)
    else $error("cause flag not set by watchdog reset");
  AST_OFF_QUIET: assert property (!opt_byte[4] |-> !wd_reset_req)
    else $error("reset request while counting disabled");
  AST_BITOP_FAULT: assert property (bitop_wr |-> ##[1:4] wd_reset_req)
    else $error("single-bit access gave no reset");
  AST_RD_CLEAR: assert property (clr_rd |=> s_axi_rdata[7:0] ==
    (opt_byte[4] ? RD_ENABLED : RD_DISABLED)) else $error("clear register read wrong");
  AST_R_LAT: assert property (ar_take |=> s_axi_rvalid)
    else $error("read data late");
  AST_B_LAT: assert property (aw_take |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write accepted before response");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted before data taken");
  COV_RESET: cover property (wd_reset_req);
  COV_IRQ: cover property (interval_irq);
  COV_WRITE: cover property (aw_take ##[1:3] s_axi_bvalid);
endmodule

bind windowed_watchdog_timer wdt_checker i_wdt_checker (.aclk, .aresetn, .opt_byte,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .wd_reset_req,
  .wd_reset_cause_flag, .interval_irq);

// file: test/windowed_watchdog_timer_tb.sv
`timescale 1ns/10ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin failures++; \
  $display("[FAIL] t=%0t got %0h exp %0h", $time, a, e); end end
module windowed_watchdog_timer_tb;
  import wdt_pkg::*;
  logic              aclk = 1'b0, aresetn = 1'b0, fil_tick = 1'b0;
  logic              halt_mode = 1'b0, stop_mode = 1'b0;
  logic [7:0]        opt_byte = 8'h00;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata, rdat, exp_w;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp, rsp;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic              s_axi_rvalid, s_axi_rready;
  logic              wd_reset_req, wd_reset_cause_flag, interval_irq;
  int                failures = 0, num_checks = 0, n_rst = 0, n_irq = 0;
  int                len [5] = '{64, 128, 256, 512, 2048};

  initial forever #20 aclk = ~aclk;

  windowed_watchdog_timer i_windowed_watchdog_timer (.aclk, .aresetn, .opt_byte,
    .fil_tick, .halt_mode, .stop_mode, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wd_reset_req,
    .wd_reset_cause_flag, .interval_irq);

  cpu_master u_cpu (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  always @(posedge aclk)
  begin
    if (wd_reset_req === 1'b1) n_rst++;
    if (interval_irq === 1'b1) n_irq++;
  end

  task report_and_stop;
    if (failures == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task start(input logic [7:0] o);
    aresetn <= 1'b0;
    opt_byte <= o;
    halt_mode <= 1'b0;
    stop_mode <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    n_rst = 0;
    n_irq = 0;
  endtask

  task tick(input int n);
    repeat (n)
    begin
      fil_tick <= 1'b1;
      @(posedge aclk);
      fil_tick <= 1'b0;
      @(posedge aclk);
    end
  endtask

  // Event counts are read at a falling edge so they never race the counting process.
  task ev(input int r, input int i);
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    `CHK(n_rst, r)
    `CHK(n_irq, i)
    n_rst = 0;
    n_irq = 0;
    @(posedge aclk);
  endtask

  task key;
    u_cpu.wr(IDX_CLEAR, CLEAR_KEY, rsp);
  endtask

  initial
  begin
    repeat (60000) @(posedge aclk);
    failures++;
    report_and_stop;
  end

  initial
  begin
    start(8'hB1);
    u_cpu.rd(IDX_CLEAR, rdat, rsp);
    `CHK(rdat[7:0], RD_ENABLED)
    key;
    `CHK(rsp, RESP_OKAY)
    ev(0, 0);
    tick(10);
    key;
    ev(1, 0);
    `CHK(wd_reset_cause_flag, 1'b1)
    u_cpu.wr(IDX_CAUSE, 8'h10, rsp);
    ev(0, 0);
    `CHK(wd_reset_cause_flag, 1'b0)
    key;
    tick(41);
    key;
    ev(0, 0);
    tick(48);
    ev(0, 0);
    tick(1);
    ev(0, 1);
    tick(15);
    ev(0, 0);
    tick(1);
    ev(1, 0);
    tick(63);
    ev(0, 1);
    key;
    tick(1);
    ev(0, 0);
    tick(63);
    ev(0, 1);
    tick(1);
    ev(1, 0);
    u_cpu.wr(IDX_CLEAR, 8'h55, rsp);
    ev(1, 0);
    u_cpu.wr(IDX_BITOP, CLEAR_KEY, rsp);
    ev(1, 0);
    u_cpu.wr(20'h00010, CLEAR_KEY, rsp);
    `CHK(rsp, RESP_SLVERR)
    u_cpu.rd(20'h00010, rdat, rsp);
    `CHK(rsp, RESP_SLVERR)
    `CHK(rdat, 32'h00000000)
    ev(0, 0);
    for (int c = 0; c < 5; c++)
    begin
      start({4'h7, c[2:0], 1'b1});
      tick(len[c] - 1);
      ev(0, 0);
      u_cpu.rd(IDX_STATUS, rdat, rsp);
      exp_w = {4'h7, c[2:0], 1'b1, 7'h00, 17'(len[c] - 1)};
      `CHK(rdat, exp_w)
      tick(1);
      ev(1, 0);
    end
    start(8'h51);
    key;
    tick(20);
    key;
    ev(0, 0);
    tick(11);
    key;
    ev(1, 0);
    start(8'h30);
    key;
    tick(6);
    key;
    ev(0, 0);
    halt_mode <= 1'b1;
    tick(100);
    ev(0, 0);
    halt_mode <= 1'b0;
    tick(63);
    ev(0, 0);
    tick(1);
    ev(1, 0);
    start(8'h31);
    stop_mode <= 1'b1;
    tick(64);
    ev(1, 0);
    start(8'h01);
    u_cpu.rd(IDX_CLEAR, rdat, rsp);
    `CHK(rdat[7:0], RD_DISABLED)
    tick(100);
    u_cpu.wr(IDX_BITOP, CLEAR_KEY, rsp);
    ev(0, 0);
    report_and_stop;
  end
endmodule
